// file: shared/pdtp_consts.vh
// Register offsets, field positions, reset values and timing counts of the DSP tuning bank.
`ifndef PDTP_CONSTS_VH
`define PDTP_CONSTS_VH

// ==========================================================
// Register indices (printed offsets); byte address is index times four.
`define PDTP_IDX_TXCLK_PHASE 12'h042
`define PDTP_IDX_DSP_CFG1 12'h101
`define PDTP_IDX_FLT_CFG1 12'h106
`define PDTP_IDX_FLT_CFG2 12'h107
`define PDTP_IDX_DSP_CFG2 12'h10F
`define PDTP_IDX_DSP_CFG3 12'h111
`define PDTP_IDX_FBE_CTRL 12'h114
`define PDTP_IDX_GAIN_BW 12'h116
`define PDTP_IDX_BAD_MSE 12'h121
`define PDTP_IDX_TL_MSE 12'h122
`define PDTP_IDX_LU_MSE 12'h123
`define PDTP_IDX_TRAIN_TMR 12'h126
`define PDTP_IDX_DSP_CFG4 12'h129

// ==========================================================
// Reset values.
`define PDTP_RST_TXCLK_PHASE 16'h0000
`define PDTP_RST_DSP_CFG1 16'h2000
`define PDTP_RST_FLT_CFG1 16'hB0BB
`define PDTP_RST_FLT_CFG2 16'h0605
`define PDTP_RST_DSP_CFG2 16'h0300
`define PDTP_RST_DSP_CFG3 16'h6003
`define PDTP_RST_FBE_CTRL 16'h400A
`define PDTP_RST_GAIN_BW 16'h014A
`define PDTP_RST_BAD_MSE 16'h199A
`define PDTP_RST_TL_MSE 16'h1027
`define PDTP_RST_LU_MSE 16'h051C
`define PDTP_RST_TRAIN_TMR 16'h461B
`define PDTP_RST_DSP_CFG4 16'h000F

// ==========================================================
// Fields and writable masks.
`define PDTP_BIT_PHASE_EN 4
`define PDTP_BIT_FLT_DIS 7
`define PDTP_BIT_COEF_EN 10
`define PDTP_BIT_LOOP_IN 8
`define PDTP_MASK_FLT_CFG1 16'hF7FF
`define PDTP_MASK_MSE 16'h7FFF

// ==========================================================
// Timing: one phase step is 4 ns; clock period 40 ns.
`define PDTP_STEP_NS 4
`define PDTP_CLK_NS 40

`endif

// file: core/pdtp_phase_shifter.v
// Transmit clock phase shifter: walks the applied phase towards the target in 4 ns steps.
`timescale 1ns/1ps
`default_nettype none
`include "pdtp_consts.vh"

module pdtp_phase_shifter #(
	parameter W = 4
) (
	input wire aclk,
	input wire aresetn,
	input wire apply,
	input wire [W-1:0] target,
	output reg [W-1:0] phase_r,
	output reg busy_r,
	output reg [2*W+1:0] shift_ns_r
);
	reg [W-1:0] goal_r;
	wire [W-1:0] new_diff = (target > phase_r) ? (target - phase_r) : (phase_r - target);

	// ==========================================================
	// Stepping.
	// The applied phase moves one unit per cycle so the clock edge never jumps more than 4 ns.
	always @(posedge aclk) begin
		if (!aresetn) begin
			phase_r <= {W{1'b0}};
			goal_r <= {W{1'b0}};
			busy_r <= 1'b0;
			shift_ns_r <= {(2*W+2){1'b0}};
		end else if (apply) begin
			goal_r <= target;
			busy_r <= (target != phase_r);
			// Four nanoseconds per unit is a shift by two, exact at any width.
			shift_ns_r <= {{W{1'b0}}, new_diff, 2'b00};
		end else if (busy_r) begin
			if (goal_r > phase_r) begin
				phase_r <= phase_r + {{(W-1){1'b0}}, 1'b1};
			end else begin
				phase_r <= phase_r - {{(W-1){1'b0}}, 1'b1};
			end
			busy_r <= ((goal_r > phase_r) ? (goal_r - phase_r) : (phase_r - goal_r))
				!= {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule // pdtp_phase_shifter

`default_nettype wire

// file: core/pdtp_bank.v
// DSP tuning and transmit clock phase register bank behind an AXI4-Lite slave.
// Contract
// - Writing 1 to bit 4 applies phase shift; bit self-clears; 0 changes nothing.
// - Bits 3:0 read back present transmit clock phase offset.
// - A new phase value shifts the clock 4 ns per unit of difference.
// - Bit 7 set disables receive filter during link-up training phase.
// - Bit 10 set enables filter coefficients in steady state.
// - Two short-cable thresholds, bits 15:12 and 3:0, reset 1011.
// - Bits 7:6, reset 10, select long-cable filter coefficients.
// - Bit 8 of second config, reset 1, selects gain loop input.
// - Gain loop starts from index in bits 3:0, reset 011.
// - Gain index limited: max bits 7:4 reset 0000, min bits 3:0 1111.
// - Bad error threshold bits 14:0 triggers recovery from steady state.
// - First good error threshold bits 14:0 gates timing loop.
// - Second good error threshold bits 14:0 qualifies link-up.
// - Timer 1 bits 14:12, reset 100, paces DSP state transitions.
// - Timer 2 bits 11:6, reset 011000, paces the timing loop.
// - Timers 3 and 4, bits 5:3 and 2:0, reset 011, pace gain loop.
`timescale 1ns/1ps
`default_nettype none
`include "pdtp_consts.vh"

module pdtp_bank (
	input wire aclk,
	input wire aresetn,
	input wire [13:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [13:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg [3:0] txclk_phase_r,
	output reg txclk_shift_busy_r,
	output reg filter_disable_r,
	output reg coef_enable_r,
	output reg [3:0] short_thresh_set1_r,
	output reg [3:0] short_thresh_set0_r,
	output reg [1:0] long_coef_sel_r,
	output reg loop_input_sel_r,
	output reg [3:0] start_gain_index_r,
	output reg [3:0] max_gain_index_r,
	output reg [3:0] min_gain_index_r,
	output reg [14:0] bad_mse_thresh_r,
	output reg [14:0] good_mse1_thresh_r,
	output reg [14:0] good_mse2_thresh_r,
	output reg [2:0] train_timer1_r,
	output reg [5:0] train_timer2_r,
	output reg [2:0] train_timer3_r,
	output reg [2:0] train_timer4_r
);
	localparam [1:0] RESP_OKAY = 2'b00;
	localparam [1:0] RESP_DECERR = 2'b11;

	// ==========================================================
	// Register storage.
	reg [3:0] phase_target_r;
	reg [15:0] dsp_cfg1_r;
	reg [15:0] flt_cfg1_r;
	reg [15:0] flt_cfg2_r;
	reg [15:0] dsp_cfg2_r;
	reg [15:0] dsp_cfg3_r;
	reg [15:0] fbe_ctrl_r;
	reg [15:0] gain_bw_r;
	reg [15:0] bad_mse_r;
	reg [15:0] tl_mse_r;
	reg [15:0] lu_mse_r;
	reg [15:0] train_tmr_r;
	reg [15:0] dsp_cfg4_r;
	reg phase_apply_r;

	// ==========================================================
	// Write channel: address and data are latched independently, in either order.
	// Only byte lanes 0 and 1 hold register bits; the upper lanes are dropped.
	reg aw_held_r;
	reg w_held_r;
	reg [11:0] aw_idx_r;
	reg [15:0] wdata_r;
	reg [1:0] wstrb_r;
	wire wr_go = aw_held_r && w_held_r && !s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_idx_r <= 12'h000;
			wdata_r <= 16'h0000;
			wstrb_r <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_idx_r <= s_axi_awaddr[13:2];
				s_axi_awready <= 1'b0;
			end else if (wr_go) begin
				aw_held_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata[15:0];
				wstrb_r <= s_axi_wstrb[1:0];
				s_axi_wready <= 1'b0;
			end else if (wr_go) begin
				w_held_r <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	function [15:0] merge;
		input [15:0] old;
		input [15:0] nw;
		input [1:0] strb;
		input [15:0] mask;
		reg [15:0] m;
		begin
			m = {{8{strb[1]}}, {8{strb[0]}}} & mask;
			merge = (old & ~m) | (nw & m);
		end
	endfunction

	reg wr_hit;
	always @* begin
		case (aw_idx_r)
			`PDTP_IDX_TXCLK_PHASE, `PDTP_IDX_DSP_CFG1, `PDTP_IDX_FLT_CFG1,
			`PDTP_IDX_FLT_CFG2, `PDTP_IDX_DSP_CFG2, `PDTP_IDX_DSP_CFG3,
			`PDTP_IDX_FBE_CTRL, `PDTP_IDX_GAIN_BW, `PDTP_IDX_BAD_MSE,
			`PDTP_IDX_TL_MSE, `PDTP_IDX_LU_MSE, `PDTP_IDX_TRAIN_TMR,
			`PDTP_IDX_DSP_CFG4: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// Reserved writable bits keep whatever software writes; read-only bits keep their pattern.
	always @(posedge aclk) begin
		if (!aresetn) begin
			phase_target_r <= 4'h0;
			phase_apply_r <= 1'b0;
			dsp_cfg1_r <= `PDTP_RST_DSP_CFG1;
			flt_cfg1_r <= `PDTP_RST_FLT_CFG1;
			flt_cfg2_r <= `PDTP_RST_FLT_CFG2;
			dsp_cfg2_r <= `PDTP_RST_DSP_CFG2;
			dsp_cfg3_r <= `PDTP_RST_DSP_CFG3;
			fbe_ctrl_r <= `PDTP_RST_FBE_CTRL;
			gain_bw_r <= `PDTP_RST_GAIN_BW;
			bad_mse_r <= `PDTP_RST_BAD_MSE;
			tl_mse_r <= `PDTP_RST_TL_MSE;
			lu_mse_r <= `PDTP_RST_LU_MSE;
			train_tmr_r <= `PDTP_RST_TRAIN_TMR;
			dsp_cfg4_r <= `PDTP_RST_DSP_CFG4;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			phase_apply_r <= 1'b0;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_DECERR;
				case (aw_idx_r)
					`PDTP_IDX_TXCLK_PHASE: begin
						if (wstrb_r[0]) begin
							phase_target_r <= wdata_r[3:0];
							phase_apply_r <= wdata_r[`PDTP_BIT_PHASE_EN];
						end
					end
					`PDTP_IDX_DSP_CFG1: begin
						dsp_cfg1_r <= merge(dsp_cfg1_r, wdata_r, wstrb_r, 16'hFFFF);
					end
					`PDTP_IDX_FLT_CFG1: flt_cfg1_r <= merge(flt_cfg1_r, wdata_r, wstrb_r,
						`PDTP_MASK_FLT_CFG1);
					`PDTP_IDX_FLT_CFG2: begin
						flt_cfg2_r <= merge(flt_cfg2_r, wdata_r, wstrb_r, 16'hFFFF);
					end
					`PDTP_IDX_DSP_CFG2: begin
						dsp_cfg2_r <= merge(dsp_cfg2_r, wdata_r, wstrb_r, 16'hFFFF);
					end
					`PDTP_IDX_DSP_CFG3: begin
						dsp_cfg3_r <= merge(dsp_cfg3_r, wdata_r, wstrb_r, 16'hFFFF);
					end
					`PDTP_IDX_FBE_CTRL: begin
						fbe_ctrl_r <= merge(fbe_ctrl_r, wdata_r, wstrb_r, 16'hFFFF);
					end
					`PDTP_IDX_GAIN_BW: begin
						gain_bw_r <= merge(gain_bw_r, wdata_r, wstrb_r, 16'hFFFF);
					end
					`PDTP_IDX_BAD_MSE: bad_mse_r <= merge(bad_mse_r, wdata_r, wstrb_r,
						`PDTP_MASK_MSE);
					`PDTP_IDX_TL_MSE: begin
						tl_mse_r <= merge(tl_mse_r, wdata_r, wstrb_r, `PDTP_MASK_MSE);
					end
					`PDTP_IDX_LU_MSE: begin
						lu_mse_r <= merge(lu_mse_r, wdata_r, wstrb_r, `PDTP_MASK_MSE);
					end
					`PDTP_IDX_TRAIN_TMR: begin
						train_tmr_r <= merge(train_tmr_r, wdata_r, wstrb_r, 16'hFFFF);
					end
					`PDTP_IDX_DSP_CFG4: begin
						dsp_cfg4_r <= merge(dsp_cfg4_r, wdata_r, wstrb_r, 16'hFFFF);
					end
					default: begin
					end
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Phase shifter.
	wire [3:0] cur_phase;
	wire shift_busy;
	pdtp_phase_shifter #(
		.W(4)
	) u_shift (
		.aclk(aclk),
		.aresetn(aresetn),
		.apply(phase_apply_r),
		.target(phase_target_r),
		.phase_r(cur_phase),
		.busy_r(shift_busy),
		.shift_ns_r()
	);

	// ==========================================================
	// Read channel: one cycle from address acceptance to data.
	// The phase register returns the applied phase, so a poll sees it walk to its target.
	reg [15:0] rd_val;
	reg rd_hit;
	always @* begin
		rd_hit = 1'b1;
		case (s_axi_araddr[13:2])
			`PDTP_IDX_TXCLK_PHASE: rd_val = {12'h000, txclk_phase_r};
			`PDTP_IDX_DSP_CFG1: rd_val = dsp_cfg1_r;
			`PDTP_IDX_FLT_CFG1: rd_val = flt_cfg1_r;
			`PDTP_IDX_FLT_CFG2: rd_val = flt_cfg2_r;
			`PDTP_IDX_DSP_CFG2: rd_val = dsp_cfg2_r;
			`PDTP_IDX_DSP_CFG3: rd_val = dsp_cfg3_r;
			`PDTP_IDX_FBE_CTRL: rd_val = fbe_ctrl_r;
			`PDTP_IDX_GAIN_BW: rd_val = gain_bw_r;
			`PDTP_IDX_BAD_MSE: rd_val = bad_mse_r;
			`PDTP_IDX_TL_MSE: rd_val = tl_mse_r;
			`PDTP_IDX_LU_MSE: rd_val = lu_mse_r;
			`PDTP_IDX_TRAIN_TMR: rd_val = train_tmr_r;
			`PDTP_IDX_DSP_CFG4: rd_val = dsp_cfg4_r;
			default: begin
				rd_val = 16'h0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {16'h0000, rd_val};
			s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ==========================================================
	// Field outputs, registered for the DSP datapath.
	// Their reset values are cut from the register reset words, so an output never
	// steps away from its reset value on the first cycle after reset.
	localparam [15:0] RST_PHASE = `PDTP_RST_TXCLK_PHASE;
	localparam [15:0] RST_DSP1 = `PDTP_RST_DSP_CFG1;
	localparam [15:0] RST_FLT1 = `PDTP_RST_FLT_CFG1;
	localparam [15:0] RST_DSP2 = `PDTP_RST_DSP_CFG2;
	localparam [15:0] RST_DSP3 = `PDTP_RST_DSP_CFG3;
	localparam [15:0] RST_DSP4 = `PDTP_RST_DSP_CFG4;
	localparam [15:0] RST_BAD = `PDTP_RST_BAD_MSE;
	localparam [15:0] RST_TL = `PDTP_RST_TL_MSE;
	localparam [15:0] RST_LU = `PDTP_RST_LU_MSE;
	localparam [15:0] RST_TMR = `PDTP_RST_TRAIN_TMR;

	always @(posedge aclk) begin
		if (!aresetn) begin
			txclk_phase_r <= RST_PHASE[3:0];
			txclk_shift_busy_r <= 1'b0;
			filter_disable_r <= RST_DSP1[`PDTP_BIT_FLT_DIS];
			coef_enable_r <= RST_FLT1[`PDTP_BIT_COEF_EN];
			short_thresh_set1_r <= RST_FLT1[15:12];
			short_thresh_set0_r <= RST_FLT1[3:0];
			long_coef_sel_r <= RST_FLT1[7:6];
			loop_input_sel_r <= RST_DSP2[`PDTP_BIT_LOOP_IN];
			start_gain_index_r <= RST_DSP3[3:0];
			max_gain_index_r <= RST_DSP4[7:4];
			min_gain_index_r <= RST_DSP4[3:0];
			bad_mse_thresh_r <= RST_BAD[14:0];
			good_mse1_thresh_r <= RST_TL[14:0];
			good_mse2_thresh_r <= RST_LU[14:0];
			train_timer1_r <= RST_TMR[14:12];
			train_timer2_r <= RST_TMR[11:6];
			train_timer3_r <= RST_TMR[5:3];
			train_timer4_r <= RST_TMR[2:0];
		end else begin
			txclk_phase_r <= cur_phase;
			txclk_shift_busy_r <= shift_busy;
			filter_disable_r <= dsp_cfg1_r[`PDTP_BIT_FLT_DIS];
			coef_enable_r <= flt_cfg1_r[`PDTP_BIT_COEF_EN];
			short_thresh_set1_r <= flt_cfg1_r[15:12];
			short_thresh_set0_r <= flt_cfg1_r[3:0];
			long_coef_sel_r <= flt_cfg1_r[7:6];
			loop_input_sel_r <= dsp_cfg2_r[`PDTP_BIT_LOOP_IN];
			start_gain_index_r <= dsp_cfg3_r[3:0];
			max_gain_index_r <= dsp_cfg4_r[7:4];
			min_gain_index_r <= dsp_cfg4_r[3:0];
			bad_mse_thresh_r <= bad_mse_r[14:0];
			good_mse1_thresh_r <= tl_mse_r[14:0];
			good_mse2_thresh_r <= lu_mse_r[14:0];
			train_timer1_r <= train_tmr_r[14:12];
			train_timer2_r <= train_tmr_r[11:6];
			train_timer3_r <= train_tmr_r[5:3];
			train_timer4_r <= train_tmr_r[2:0];
		end
	end
endmodule // pdtp_bank

`default_nettype wire

// file: tb/pdtp_bank_props.sv
// Concurrent checks on the ports of the DSP tuning register bank.
`timescale 1ns/1ps
`default_nettype none
module pdtp_props (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [3:0] txclk_phase_r,
	input wire filter_disable_r,
	input wire coef_enable_r,
	input wire [3:0] min_gain_index_r
);
// ========
// Helpers
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
// Fields may only move shortly after a write, so a stray update is caught.
logic [3:0] since_wr_r;
always_ff @(posedge aclk) begin
	if (!aresetn)
		since_wr_r <= 4'hF;
	else if (!s_axi_awready)
		since_wr_r <= 4'h0;
	else if (since_wr_r != 4'hF)
		since_wr_r <= since_wr_r + 4'h1;
end
sequence wr_taken;
	s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence
sequence rd_taken;
	s_axi_arvalid && s_axi_arready;
endsequence
// ========
// Assertions
a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid) else $error("no bvalid");
a_read_answer: assert property (rd_taken |-> ##[1:2] s_axi_rvalid) else $error("no rvalid");
a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
	&& $stable(s_axi_bresp)) else $error("bvalid dropped");
a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
	&& $stable(s_axi_rdata)) else $error("rvalid dropped");
a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
	else $error("write accepted early");
a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
	else $error("upper read half set");
a_phase_step: assert property ($changed(txclk_phase_r) |->
	txclk_phase_r == $past(txclk_phase_r) + 4'h1 || txclk_phase_r == $past(txclk_phase_r) - 4'h1)
	else $error("phase jumped");
a_fltdis_cause: assert property ($changed(filter_disable_r) |-> since_wr_r < 4'h4)
	else $error("filter bit moved");
a_coef_cause: assert property ($changed(coef_enable_r) |-> since_wr_r < 4'h4)
	else $error("coef bit moved");
a_mingain_cause: assert property ($changed(min_gain_index_r) |-> since_wr_r < 4'h4)
	else $error("gain limit moved");
endmodule // pdtp_props
bind pdtp_bank pdtp_props u_props (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.txclk_phase_r(txclk_phase_r),
	.filter_disable_r(filter_disable_r),
	.coef_enable_r(coef_enable_r),
	.min_gain_index_r(min_gain_index_r)
);
`default_nettype wire

// file: tb/pdtp_bank_tb.sv
// Self-checking bench for the DSP tuning register bank.
`timescale 1ns/1ps
`default_nettype none
`include "pdtp_consts.vh"
module pdtp_bank_tb;
// ========
// Signals
logic aclk = 1'b0;
logic aresetn = 1'b0;
logic [13:0] s_axi_awaddr = 14'h0000;
logic [13:0] s_axi_araddr = 14'h0000;
logic [31:0] s_axi_wdata = 32'h0000_0000;
logic [3:0] s_axi_wstrb = 4'h0;
logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire [1:0] s_axi_bresp, s_axi_rresp, long_coef_sel_r;
wire [31:0] s_axi_rdata;
wire [3:0] txclk_phase_r, short_thresh_set1_r, short_thresh_set0_r, start_gain_index_r;
wire [3:0] max_gain_index_r, min_gain_index_r;
wire txclk_shift_busy_r, filter_disable_r, coef_enable_r, loop_input_sel_r;
wire [14:0] bad_mse_thresh_r, good_mse1_thresh_r, good_mse2_thresh_r;
wire [2:0] train_timer1_r, train_timer3_r, train_timer4_r;
wire [5:0] train_timer2_r;
integer num_errors = 0, n_compared = 0, seed = 32'h35324ded, cyc = 0, i;
logic [1:0] resp;
logic [31:0] rd;
logic [3:0] ph;
logic [15:0] v [0:12];
logic [4:0] pw [0:4] = '{5'h12, 5'h19, 5'h10, 5'h1F, 5'h05};
logic [11:0] ix [0:12] = '{`PDTP_IDX_TXCLK_PHASE, `PDTP_IDX_DSP_CFG1, `PDTP_IDX_FLT_CFG1,
	`PDTP_IDX_FLT_CFG2, `PDTP_IDX_DSP_CFG2, `PDTP_IDX_DSP_CFG3, `PDTP_IDX_FBE_CTRL,
	`PDTP_IDX_GAIN_BW, `PDTP_IDX_BAD_MSE, `PDTP_IDX_TL_MSE, `PDTP_IDX_LU_MSE,
	`PDTP_IDX_TRAIN_TMR, `PDTP_IDX_DSP_CFG4};
logic [15:0] rs [0:12] = '{16'h0000, 16'h2000, 16'hB0BB, 16'h0605, 16'h0300, 16'h6003,
	16'h400A, 16'h014A, 16'h199A, 16'h1027, 16'h051C, 16'h461B, 16'h000F};
pdtp_bank dut (.*);
initial forever #20 aclk = ~aclk;
// ========
// Tasks
function automatic logic [15:0] msk(input integer k);
	return (k == 2) ? 16'hF7FF : (k >= 8 && k <= 10) ? 16'h7FFF : 16'hFFFF;
endfunction
task chk(input logic [31:0] got, input logic [31:0] exp);
	n_compared = n_compared + 1;
	if (got !== exp) begin
		num_errors = num_errors + 1;
		$display("unexpected at %0t: got %h want %h", $time, got, exp);
	end
endtask
// Response ready is raised late at random so the slave must hold its answer.
task wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] sb);
	@(posedge aclk);
	s_axi_awaddr <= {a, 2'b00};
	s_axi_wdata <= {16'h0000, d};
	s_axi_wstrb <= {2'b00, sb};
	s_axi_awvalid <= 1'b1;
	s_axi_wvalid <= 1'b1;
	do begin
		@(posedge aclk);
		if (s_axi_awready) s_axi_awvalid <= 1'b0;
		if (s_axi_wready) s_axi_wvalid <= 1'b0;
	end while (s_axi_awvalid || s_axi_wvalid);
	repeat ($random(seed) & 3) @(posedge aclk);
	s_axi_bready <= 1'b1;
	do @(posedge aclk); while (!(s_axi_bready && s_axi_bvalid));
	resp = s_axi_bresp;
	s_axi_bready <= 1'b0;
endtask
task rdr(input logic [11:0] a);
	@(posedge aclk);
	s_axi_araddr <= {a, 2'b00};
	s_axi_arvalid <= 1'b1;
	do @(posedge aclk); while (!s_axi_arready);
	s_axi_arvalid <= 1'b0;
	repeat ($random(seed) & 3) @(posedge aclk);
	s_axi_rready <= 1'b1;
	do @(posedge aclk); while (!(s_axi_rready && s_axi_rvalid));
	rd = s_axi_rdata;
	resp = s_axi_rresp;
	s_axi_rready <= 1'b0;
endtask
task end_of_test;
	$display("compared %0d, errors %0d", n_compared, num_errors);
	if (num_errors == 0 && n_compared > 0)
		$display("Test passed");
	else
		$display("Test failed");
	$finish;
endtask
initial forever begin
	@(posedge aclk);
	cyc = cyc + 1;
	if (cyc == 5000) begin
		num_errors = num_errors + 1;
		$display("unexpected at %0t: timeout", $time);
		end_of_test;
	end
end
// ========
// Scenarios
initial begin
	repeat (5) @(posedge aclk);
	aresetn <= 1'b1;
	for (i = 0; i < 13; i = i + 1) begin
		rdr(ix[i]);
		chk(rd, {16'h0000, rs[i]});
		chk(resp, 2'b00);
	end
	chk({short_thresh_set1_r, short_thresh_set0_r, long_coef_sel_r, loop_input_sel_r},
		{4'hB, 4'hB, 2'b10, 1'b1});
	chk({start_gain_index_r, max_gain_index_r, min_gain_index_r}, 12'h30F);
	chk({train_timer1_r, train_timer2_r, train_timer3_r, train_timer4_r},
		{3'h4, 6'h18, 3'h3, 3'h3});
	$display("reset values done");
	for (i = 1; i < 13; i = i + 1) begin
		v[i] = 16'($random(seed));
		wr(ix[i], v[i], 2'b11);
		chk(resp, 2'b00);
		rdr(ix[i]);
		chk(rd, {16'h0000, v[i] & msk(i)});
	end
	wr(ix[12], 16'h5AF0, 2'b01);
	v[12][7:0] = 8'hF0;
	rdr(ix[12]);
	chk(rd, {16'h0000, v[12]});
	chk({filter_disable_r, coef_enable_r, short_thresh_set1_r, short_thresh_set0_r,
		long_coef_sel_r, loop_input_sel_r}, {v[1][7], v[2][10], v[2][15:12], v[2][3:0],
		v[2][7:6], v[4][8]});
	chk({start_gain_index_r, max_gain_index_r, min_gain_index_r},
		{v[5][3:0], v[12][7:4], v[12][3:0]});
	chk({bad_mse_thresh_r, good_mse1_thresh_r}, {v[8][14:0], v[9][14:0]});
	chk({good_mse2_thresh_r, train_timer1_r, train_timer2_r, train_timer3_r,
		train_timer4_r}, {v[10][14:0], v[11][14:0]});
	wr(12'h100, 16'hFFFF, 2'b11);
	chk(resp, 2'b11);
	rdr(12'h100);
	chk(resp, 2'b11);
	chk(rd, 32'h0000_0000);
	$display("register data done");
	ph = 4'h0;
	for (i = 0; i < 5; i = i + 1) begin
		wr(ix[0], {11'h000, pw[i]}, 2'b11);
		if (pw[i][4]) ph = pw[i][3:0];
		repeat (2) @(posedge aclk);
		while (txclk_shift_busy_r) @(posedge aclk);
		repeat (2) @(posedge aclk);
		rdr(ix[0]);
		chk(rd, {28'h000_0000, ph});
		chk(txclk_phase_r, ph);
	end
	$display("phase shift done");
	@(posedge aclk);
	aresetn <= 1'b0;
	repeat (5) @(posedge aclk);
	aresetn <= 1'b1;
	rdr(ix[12]);
	chk(rd, {16'h0000, rs[12]});
	chk(txclk_phase_r, 4'h0);
	$display("second reset done");
	end_of_test;
end
endmodule // pdtp_bank_tb
`default_nettype wire
